// File: verilog/tts_defs.vh
`ifndef TTS_DEFS_VH
`define TTS_DEFS_VH
// --------
// timing
// --------
`define TTS_MCLK_MHZ 100
// stop delay, write family
`define TTS_STOP_WR_US 2720
// stop delay, read and space
`define TTS_STOP_RD_US 1820
// strobe and halt width
`define TTS_STROBE_NS 200
// delay count tick period
`define TTS_TICK_NS 11000
// --------
// register map, fields and codes
// --------
`define TTS_REG_CTRL 4'h0
`define TTS_REG_COUNT 4'h4
`define TTS_REG_STATUS 4'h8
`define TTS_CTRL_GO 0
`define TTS_CTRL_STOP 1
`define TTS_CTRL_OP_LSB 4
`define TTS_CTRL_UNIT_LSB 8
`define TTS_COUNT_RST 16'h0001
`define TTS_OP_READ 3'h0
`define TTS_OP_WRITE 3'h1
`define TTS_OP_XGAP 3'h2
`define TTS_OP_FMARK 3'h3
`define TTS_OP_SPACE_AHEAD 3'h4
`define TTS_OP_SPACE_BACK 3'h5
`define TTS_OP_REWIND 3'h6
`define TTS_OP_OFFLINE 3'h7
`define TTS_RESP_OKAY 2'h0
`define TTS_RESP_SLVERR 2'h2
`endif

// File: verilog/tts_delay_cnt.v
`include "tts_defs.vh"
`default_nettype none
// --------
// motion delay counter: preset load, then count to bit 14
// --------
module tts_delay_cnt #(
    parameter DATA_W = 9,
    parameter TICK_CYC = `TTS_TICK_NS * `TTS_MCLK_MHZ / 1000
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // transport side
    input wire preset_gate,
    input wire [DATA_W-1:0] preset,
    // control
    input wire clear,
    // results
    output reg up_to_speed,
    output reg read_window
);
    localparam [11:0] TICK_C = TICK_CYC[11:0];
    reg [14:0] cnt_q;
    reg armed_q;
    reg [11:0] div_q;
    wire tick = (div_q == 12'h000);

    // free running tick divider; start delays are the count left to bit 14 times tick
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            div_q <= 12'h000;
        else if (tick)
            div_q <= TICK_C - 12'h001;
        else
            div_q <= div_q - 12'h001;
    end

    // presets sit just under bit 14, so the preset sets the remaining count
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 15'h0000;
            armed_q <= 1'b0;
            up_to_speed <= 1'b0;
            read_window <= 1'b0;
        end
        else if (clear)
        begin
            armed_q <= 1'b0;
            up_to_speed <= 1'b0;
            read_window <= 1'b0;
        end
        else if (preset_gate)
        begin
            cnt_q <= {1'b0, preset, {(14-DATA_W){1'b0}}};
            armed_q <= 1'b1;
            up_to_speed <= 1'b0;
            read_window <= 1'b0;
        end
        else if (armed_q && cnt_q[14])
        begin
            armed_q <= 1'b0; // further counting inhibited
            up_to_speed <= 1'b1;
            read_window <= 1'b1;
        end
        else if (armed_q && tick)
            cnt_q <= cnt_q + 15'h0001;
    end
endmodule
`default_nettype wire

// File: verilog/tts_axil_regs.v
`include "tts_defs.vh"
`default_nettype none
// --------
// axi4-lite slave holding the command and status words
// --------
module tts_axil_regs (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // write channels
    input wire [3:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // read channels
    input wire [3:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // block side
    output reg [2:0] op,
    output reg [2:0] unit,
    output reg [15:0] count,
    output reg go,
    output reg stop,
    input wire [31:0] status,
    input wire [15:0] remaining
);
    reg [3:0] aw_q;
    reg [31:0] w_q;
    reg [3:0] ws_q;
    reg aw_have_q;
    reg w_have_q;
    wire do_wr = aw_have_q && w_have_q && !bvalid;

    // write path: address and data taken in either order
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_q <= 4'h0;
            w_q <= 32'h00000000;
            ws_q <= 4'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `TTS_RESP_OKAY;
            op <= `TTS_OP_READ;
            unit <= 3'h0;
            count <= `TTS_COUNT_RST;
            go <= 1'b0;
            stop <= 1'b0;
        end
        else
        begin
            go <= 1'b0;
            stop <= 1'b0;
            if (awvalid && awready)
            begin
                aw_q <= awaddr;
                aw_have_q <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_q <= wdata;
                ws_q <= wstrb;
                w_have_q <= 1'b1;
                wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `TTS_RESP_OKAY;
                // byte 0: go, stop, op; byte 1: unit
                if (aw_q == `TTS_REG_CTRL)
                begin
                    if (ws_q[0])
                    begin
                        go <= w_q[`TTS_CTRL_GO];
                        stop <= w_q[`TTS_CTRL_STOP];
                        op <= w_q[`TTS_CTRL_OP_LSB+2:`TTS_CTRL_OP_LSB];
                    end
                    if (ws_q[1])
                        unit <= w_q[`TTS_CTRL_UNIT_LSB+2:`TTS_CTRL_UNIT_LSB];
                end
                else if (aw_q == `TTS_REG_COUNT)
                begin
                    if (ws_q[0])
                        count[7:0] <= w_q[7:0];
                    if (ws_q[1])
                        count[15:8] <= w_q[15:8];
                end
                else if (aw_q != `TTS_REG_STATUS)
                    bresp <= `TTS_RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // read path: answer on the same edge that takes the address
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `TTS_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= `TTS_RESP_OKAY;
            case (araddr)
                `TTS_REG_CTRL: rdata <= {21'h000000, unit, 1'b0, op, 4'h0};
                `TTS_REG_COUNT: rdata <= {remaining, count};
                `TTS_REG_STATUS: rdata <= status;
                default:
                begin
                    rdata <= 32'h00000000;
                    rresp <= `TTS_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: verilog/tts_ctrl.v
// Contract
// - presets on read lines loaded under gate
// - count to bit 14, then flags, stop
// - write start delays 184.60 / 8.99 ms
// - read start delays 150.60 / 2.72 ms
// - stop delays 2.72 and 1.82 ms
// - read window enables read, speed enables clock
// - motion continues until halt line asserted
// - rewind: halt right after set strobe ends
// - space: stop delay, halt per check character
// - space: restart on slowing, delays alternate
// - three bit unit select, match connects
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`include "tts_defs.vh"
`default_nettype none
module tts_ctrl #(
    parameter DATA_W = 9,
    parameter STOP_WR_CYC = `TTS_STOP_WR_US * `TTS_MCLK_MHZ,
    parameter STOP_RD_CYC = `TTS_STOP_RD_US * `TTS_MCLK_MHZ,
    parameter STROBE_CYC = `TTS_STROBE_NS * `TTS_MCLK_MHZ / 1000,
    parameter TICK_CYC = `TTS_TICK_NS * `TTS_MCLK_MHZ / 1000
) (
    // clock and reset
    input wire MCLK,
    input wire ARST_N,
    // axi4-lite write channels
    input wire [3:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output wire [1:0] S_AXI_BRESP,
    output wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // axi4-lite read channels
    input wire [3:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0] S_AXI_RRESP,
    output wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // slave bus commands to the transport
    output reg [2:0] UNIT_SEL,
    output reg CMD_FORWARD,
    output reg CMD_BACKWARD,
    output reg CMD_REWIND,
    output reg CMD_WRITE,
    output reg CMD_XGAP,
    output reg DRIVE_CMD_STROBE,
    output reg TRANSPORT_SET_STROBE,
    output reg HALT_MOTION,
    output wire UP_TO_SPEED,
    output wire READ_WINDOW,
    // slave bus status from the transport
    input wire PRESET_GATE_ENABLE,
    input wire [DATA_W-1:0] RD_DATA,
    input wire TAPE_LOADED,
    input wire REWINDING,
    input wire SETTLING_AFTER_STOP,
    input wire UNIT_IDLE_READY,
    // check character seen by the read path
    input wire CHECK_CHAR_SEEN
);
    // --------
    // constants and state codes
    // --------
    localparam [18:0] STOP_WR_C = STOP_WR_CYC[18:0];
    localparam [18:0] STOP_RD_C = STOP_RD_CYC[18:0];
    localparam [18:0] STROBE_C = STROBE_CYC[18:0];
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_SETUP = 4'h1;
    localparam [3:0] ST_STROBE = 4'h2;
    localparam [3:0] ST_RUN = 4'h3;
    localparam [3:0] ST_STOPDLY = 4'h4;
    localparam [3:0] ST_HALT = 4'h5;
    localparam [3:0] ST_SPWAIT = 4'h6;
    localparam [3:0] ST_WAITRDY = 4'h7;
    localparam [3:0] ST_REWIND = 4'h8;
    localparam [3:0] ST_RWWAIT = 4'h9;

    // --------
    // declarations
    // --------
    wire [2:0] reg_op;
    wire [2:0] reg_unit;
    wire [15:0] reg_count;
    wire go_pulse;
    wire stop_pulse;
    wire [31:0] status_word;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [18:0] cnt_q;
    reg [18:0] cnt_d;
    reg [2:0] op_q;
    reg [2:0] op_d;
    reg [15:0] left_q;
    reg [15:0] left_d;
    reg stop_req_q;
    reg fwd_d;
    reg back_d;
    reg rew_d;
    reg wr_d;
    reg xg_d;
    reg drv_d;
    reg set_d;
    reg halt_d;
    reg [2:0] sel_d;
    reg delay_clr;

    // write family decode
    function is_write;
        input [2:0] code;
        begin
            is_write = (code == `TTS_OP_WRITE) || (code == `TTS_OP_XGAP) ||
                (code == `TTS_OP_FMARK);
        end
    endfunction

    function is_space;
        input [2:0] code;
        begin
            is_space = (code == `TTS_OP_SPACE_AHEAD) || (code == `TTS_OP_SPACE_BACK);
        end
    endfunction

    // --------
    // register bus and motion delay counter
    // --------
    assign status_word = {20'h00000, state_q, TAPE_LOADED, UNIT_IDLE_READY,
        SETTLING_AFTER_STOP, REWINDING, READ_WINDOW, UP_TO_SPEED,
        stop_req_q, (state_q != ST_IDLE)};

    tts_axil_regs u_regs (
        .clk(MCLK),
        .arst_n(ARST_N),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .op(reg_op),
        .unit(reg_unit),
        .count(reg_count),
        .go(go_pulse),
        .stop(stop_pulse),
        .status(status_word),
        .remaining(left_q)
    );

    tts_delay_cnt #(
        .DATA_W(DATA_W),
        .TICK_CYC(TICK_CYC)
    ) u_delay (
        .clk(MCLK),
        .arst_n(ARST_N),
        .preset_gate(PRESET_GATE_ENABLE),
        .preset(RD_DATA),
        .clear(delay_clr),
        .up_to_speed(UP_TO_SPEED),
        .read_window(READ_WINDOW)
    );

    // --------
    // sequencer
    // --------
    // next state; lines hold for the whole op so space restarts match
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        op_d = op_q;
        left_d = left_q;
        fwd_d = CMD_FORWARD;
        back_d = CMD_BACKWARD;
        rew_d = CMD_REWIND;
        wr_d = CMD_WRITE;
        xg_d = CMD_XGAP;
        drv_d = DRIVE_CMD_STROBE;
        set_d = TRANSPORT_SET_STROBE;
        halt_d = HALT_MOTION;
        sel_d = UNIT_SEL;
        delay_clr = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                sel_d = reg_unit;
                // no strobe toward a transport that has no tape
                if (go_pulse && TAPE_LOADED)
                begin
                    op_d = reg_op;
                    left_d = (reg_count == 16'h0000) ? 16'h0001 : reg_count;
                    fwd_d = (reg_op == `TTS_OP_READ) || is_write(reg_op) ||
                        (reg_op == `TTS_OP_SPACE_AHEAD);
                    back_d = (reg_op == `TTS_OP_SPACE_BACK);
                    rew_d = (reg_op == `TTS_OP_REWIND) ||
                        (reg_op == `TTS_OP_OFFLINE);
                    wr_d = is_write(reg_op) || (reg_op == `TTS_OP_OFFLINE);
                    // longer gap request, honoured by the transport
                    xg_d = (reg_op == `TTS_OP_XGAP) || (reg_op == `TTS_OP_FMARK);
                    halt_d = 1'b0;
                    cnt_d = STROBE_C;
                    state_d = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // lines settle before the strobes fire
                if (cnt_q == 19'h00000)
                begin
                    drv_d = 1'b1;
                    set_d = 1'b1;
                    cnt_d = STROBE_C;
                    state_d = ST_STROBE;
                end
                else
                    cnt_d = cnt_q - 19'h00001;
            end
            ST_STROBE:
            begin
                if (cnt_q == 19'h00000)
                begin
                    drv_d = 1'b0;
                    set_d = 1'b0;
                    if (rew_d)
                    begin
                        halt_d = 1'b1;
                        cnt_d = STROBE_C;
                        state_d = ST_REWIND;
                    end
                    else
                        state_d = ST_RUN;
                end
                else
                    cnt_d = cnt_q - 19'h00001;
            end
            ST_RUN:
            begin
                // runs until software stops it or a space op sees a check character
                if (stop_req_q || (is_space(op_q) && CHECK_CHAR_SEEN))
                begin
                    cnt_d = is_write(op_q) ? STOP_WR_C : STOP_RD_C;
                    state_d = ST_STOPDLY;
                end
            end
            ST_STOPDLY:
            begin
                if (cnt_q == 19'h00000)
                begin
                    halt_d = 1'b1;
                    delay_clr = 1'b1;
                    cnt_d = STROBE_C;
                    state_d = ST_HALT;
                end
                else
                    cnt_d = cnt_q - 19'h00001;
            end
            ST_HALT:
            begin
                if (cnt_q == 19'h00000)
                begin
                    halt_d = 1'b0;
                    if (is_space(op_q) && !stop_req_q && (left_q != 16'h0001))
                    begin
                        left_d = left_q - 16'h0001;
                        state_d = ST_SPWAIT;
                    end
                    else
                        state_d = ST_WAITRDY;
                end
                else
                    cnt_d = cnt_q - 19'h00001;
            end
            ST_SPWAIT:
            begin
                // restart as soon as the drive starts slowing down
                if (SETTLING_AFTER_STOP)
                begin
                    drv_d = 1'b1;
                    set_d = 1'b1;
                    cnt_d = STROBE_C;
                    state_d = ST_STROBE;
                end
            end
            ST_WAITRDY:
            begin
                // unit ready means stopped and settled
                if (UNIT_IDLE_READY && !SETTLING_AFTER_STOP)
                begin
                    fwd_d = 1'b0;
                    back_d = 1'b0;
                    wr_d = 1'b0;
                    xg_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            ST_REWIND:
            begin
                // halt is held through the rewind; the transport ignores it
                if (cnt_q == 19'h00000)
                    state_d = ST_RWWAIT;
                else
                    cnt_d = cnt_q - 19'h00001;
            end
            ST_RWWAIT:
            begin
                // an offline request also ends here, once rewinding drops
                if (!REWINDING)
                begin
                    halt_d = 1'b0;
                    rew_d = 1'b0;
                    wr_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // --------
    // state and pin registers
    // --------
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 19'h00000;
            op_q <= `TTS_OP_READ;
            left_q <= 16'h0000;
            UNIT_SEL <= 3'h0;
            CMD_FORWARD <= 1'b0;
            CMD_BACKWARD <= 1'b0;
            CMD_REWIND <= 1'b0;
            CMD_WRITE <= 1'b0;
            CMD_XGAP <= 1'b0;
            DRIVE_CMD_STROBE <= 1'b0;
            TRANSPORT_SET_STROBE <= 1'b0;
            HALT_MOTION <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            left_q <= left_d;
            UNIT_SEL <= sel_d;
            CMD_FORWARD <= fwd_d;
            CMD_BACKWARD <= back_d;
            CMD_REWIND <= rew_d;
            CMD_WRITE <= wr_d;
            CMD_XGAP <= xg_d;
            DRIVE_CMD_STROBE <= drv_d;
            TRANSPORT_SET_STROBE <= set_d;
            HALT_MOTION <= halt_d;
        end
    end

    // stop request: set only outside idle; idle clears it
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            stop_req_q <= 1'b0;
        else if (stop_pulse && (state_q != ST_IDLE))
            stop_req_q <= 1'b1;
        else if (state_q == ST_IDLE)
            stop_req_q <= 1'b0;
    end
endmodule
`default_nettype wire

// File: bench/tts_ctrl_asserts.sv
`default_nettype none
// --------
// slave bus checks on the controller ports
// --------
module tts_ctrl_asserts (
    // clock and reset
    input wire logic MCLK,
    input wire logic ARST_N,
    // command lines
    input wire logic [2:0] UNIT_SEL,
    input wire logic CMD_FORWARD,
    input wire logic CMD_BACKWARD,
    input wire logic CMD_REWIND,
    input wire logic CMD_WRITE,
    input wire logic DRIVE_CMD_STROBE,
    input wire logic TRANSPORT_SET_STROBE,
    input wire logic HALT_MOTION,
    input wire logic UP_TO_SPEED,
    input wire logic READ_WINDOW,
    // status lines
    input wire logic PRESET_GATE_ENABLE,
    input wire logic REWINDING,
    input wire logic UNIT_IDLE_READY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    // strobe and halt pulses last 3 cycles
    sequence s_pulse(sig);
        sig [*3] ##1 !sig;
    endsequence
    a_strobe_pair: assert property (DRIVE_CMD_STROBE == TRANSPORT_SET_STROBE)
        else $error("strobes differ");
    a_strobe_width: assert property ($rose(DRIVE_CMD_STROBE) |-> s_pulse(DRIVE_CMD_STROBE))
        else $error("strobe width");
    a_strobe_dir: assert property (DRIVE_CMD_STROBE |-> CMD_FORWARD || CMD_BACKWARD || CMD_REWIND)
        else $error("strobe without direction");
    a_offline_pair: assert property (CMD_WRITE && CMD_REWIND |-> !CMD_FORWARD && !CMD_BACKWARD)
        else $error("offline with motion");
    a_rewind_halt: assert property ($fell(TRANSPORT_SET_STROBE) && CMD_REWIND |-> ##[0:1] HALT_MOTION)
        else $error("no halt after rewind strobe");
    a_halt_width: assert property ($rose(HALT_MOTION) && !CMD_REWIND |-> s_pulse(HALT_MOTION))
        else $error("halt width");
    a_speed_window: assert property (UP_TO_SPEED == READ_WINDOW)
        else $error("speed and window differ");
    a_gate_clears: assert property (PRESET_GATE_ENABLE |-> ##[1:2] !UP_TO_SPEED)
        else $error("speed during preset");
    a_halt_in_op: assert property (HALT_MOTION |-> CMD_FORWARD || CMD_BACKWARD || CMD_REWIND)
        else $error("halt while idle");
    a_lines_hold: assert property (CMD_FORWARD && !UNIT_IDLE_READY |=> CMD_FORWARD)
        else $error("forward dropped early");
    a_unit_frozen: assert property (CMD_FORWARD && $past(CMD_FORWARD) |-> $stable(UNIT_SEL))
        else $error("unit changed in op");
endmodule
bind tts_ctrl tts_ctrl_asserts u_chk (.*);
`default_nettype wire

// File: bench/tts_xport_model.sv
`default_nettype none
// --------
// behavioural transport on the slave bus
// --------
module tts_xport_model #(
    parameter logic [2:0] UNIT_NO = 3'h2
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic ARST_N,
    // commands
    input wire logic [2:0] UNIT_SEL,
    input wire logic CMD_FORWARD,
    input wire logic CMD_BACKWARD,
    input wire logic CMD_REWIND,
    input wire logic CMD_WRITE,
    input wire logic DRIVE_CMD_STROBE,
    input wire logic HALT_MOTION,
    // status
    output logic PRESET_GATE_ENABLE,
    output logic [8:0] RD_DATA,
    output logic TAPE_LOADED,
    output logic REWINDING,
    output logic SETTLING_AFTER_STOP,
    output logic UNIT_IDLE_READY
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fwd_q, rev_q, rws_q, wre_q, stb_q, hlt_q;
    logic [7:0] gate_q, settle_q, rwd_q;
    wire logic moving = fwd_q || rev_q || rws_q;
    assign TAPE_LOADED = 1'b1;
    assign PRESET_GATE_ENABLE = gate_q != 8'h00;
    // idle lines show the inverse preset
    assign RD_DATA = PRESET_GATE_ENABLE ? 9'h1FC : 9'h003;
    assign REWINDING = rws_q;
    assign SETTLING_AFTER_STOP = settle_q != 8'h00;
    assign UNIT_IDLE_READY = !moving && !SETTLING_AFTER_STOP;
    // motion flip-flops, cleared by a halt, the rewind count or an init
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            {fwd_q, rev_q, rws_q, wre_q, stb_q, hlt_q} <= '0;
            {gate_q, settle_q, rwd_q} <= '0;
        end
        else
        begin
            stb_q <= DRIVE_CMD_STROBE;
            hlt_q <= HALT_MOTION;
            if (gate_q != 8'h00)
                gate_q <= gate_q - 8'h01;
            if (settle_q != 8'h00)
                settle_q <= settle_q - 8'h01;
            if (rws_q)
                rwd_q <= rwd_q - 8'h01;
            if (rws_q && rwd_q == 8'h01)
                rws_q <= 1'b0;
            if (DRIVE_CMD_STROBE && !stb_q && UNIT_SEL == UNIT_NO && !moving)
            begin
                fwd_q <= CMD_FORWARD;
                rev_q <= CMD_BACKWARD;
                rws_q <= CMD_REWIND;
                wre_q <= CMD_WRITE && !CMD_REWIND;
                gate_q <= 8'h08;
                rwd_q <= 8'h50;
            end
            else if (HALT_MOTION && !hlt_q && !rws_q && moving)
            begin
                {fwd_q, rev_q, wre_q} <= '0;
                settle_q <= 8'h14;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/tb_tts_ctrl.sv
`default_nettype none
`define CHK(s, e, a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value %s exp %0h got %0h", s, e, a); end end
`define WT(c) begin n = 0; while (!(c) && n < 9000) begin @(posedge MCLK); n++; end \
    if (n >= 9000) begin err_total++; end_of_test(); end end
// --------
// bench top: axi master and scenarios
// --------
module tb_tts_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'b0, ARST_N = 1'b0, CHECK_CHAR_SEEN = 1'b0;
    logic [3:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, S_AXI_WSTRB = 4'hF;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, S_AXI_RVALID, S_AXI_BVALID;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
    logic [2:0] UNIT_SEL;
    logic [8:0] RD_DATA;
    logic CMD_FORWARD, CMD_BACKWARD, CMD_REWIND, CMD_WRITE, CMD_XGAP, HALT_MOTION;
    logic DRIVE_CMD_STROBE, TRANSPORT_SET_STROBE, UP_TO_SPEED, READ_WINDOW, REWINDING;
    logic PRESET_GATE_ENABLE, TAPE_LOADED, SETTLING_AFTER_STOP, UNIT_IDLE_READY;
    logic [31:0] d;
    int err_total = 0, comparisons = 0, n, e;
    tts_ctrl #(.STOP_WR_CYC(40), .STOP_RD_CYC(30), .STROBE_CYC(2), .TICK_CYC(2)) u_dut (.*);
    tts_xport_model u_xport (.*);
    always #5 MCLK = ~MCLK;
    task automatic end_of_test();
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // each channel is released at the edge that takes it
    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= v;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        `WT(S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WREADY)
        {S_AXI_AWVALID, S_AXI_WVALID} <= 2'h0;
        `WT(S_AXI_BVALID)
        S_AXI_BREADY <= 1'b0;
        r = S_AXI_BRESP;
    endtask
    task automatic axr(input logic [3:0] a);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        `WT(S_AXI_ARREADY && S_AXI_ARVALID)
        S_AXI_ARVALID <= 1'b0;
        `WT(S_AXI_RVALID)
        S_AXI_RREADY <= 1'b0;
        {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
    endtask
    task automatic t_regs();
        axw(4'h0, 32'h00000200);
        axr(4'h0);
        `CHK("ctrl", 32'h00000200, d)
        `CHK("unit", 3'h2, UNIT_SEL)
        axr(4'hC);
        `CHK("resp", 2'h2, r)
        axr(4'h4);
        `CHK("count", 16'h0001, d[15:0])
    endtask
    // one motion op, timed end to end
    task automatic t_run(input logic [2:0] op);
        axw(4'h0, {21'h0, 3'h2, 1'b0, op, 4'h1});
        `WT(PRESET_GATE_ENABLE)
        `CHK("forward", op != 3'h5, CMD_FORWARD)
        `CHK("backward", op == 3'h5, CMD_BACKWARD)
        `CHK("write", op inside {[1:3]}, CMD_WRITE)
        `CHK("xgap", op inside {[2:3]}, CMD_XGAP)
        `WT(!PRESET_GATE_ENABLE)
        `WT(UP_TO_SPEED)
        `CHK("count time", 1'b1, n inside {[248:264]})
        repeat (50) @(posedge MCLK);
        `CHK("halt", 1'b0, HALT_MOTION)
        e = (op inside {[1:3]} ? 41 : 31) + (op < 3'h4 ? 2 : 1);
        if (op < 3'h4)
            axw(4'h0, 32'h00000002);
        else
        begin
            CHECK_CHAR_SEEN <= 1'b1;
            @(posedge MCLK);
            CHECK_CHAR_SEEN <= 1'b0;
        end
        `WT(HALT_MOTION)
        `CHK("stop delay", 1'b1, n inside {[e - 4:e + 1]})
        `WT(!CMD_FORWARD && !CMD_BACKWARD)
        `CHK("ready", 1'b1, UNIT_IDLE_READY)
        repeat (3) @(posedge MCLK);
    endtask
    task automatic t_rw(input logic [2:0] op);
        axw(4'h0, {21'h0, 3'h2, 1'b0, op, 4'h1});
        `WT(HALT_MOTION)
        `CHK("rewind", 1'b1, CMD_REWIND)
        `CHK("offline", op == 3'h7, CMD_WRITE)
        axr(4'h8);
        `CHK("rewinding", 1'b1, d[4])
        `WT(!CMD_REWIND)
        `CHK("rewound", 1'b0, REWINDING)
        repeat (3) @(posedge MCLK);
    endtask
    initial
    begin
        repeat (8) @(posedge MCLK);
        ARST_N <= 1'b1;
        t_regs();
        for (int k = 0; k < 6; k++)
            t_run(k[2:0]);
        t_rw(3'h6);
        t_rw(3'h7);
        end_of_test();
    end
endmodule
`default_nettype wire
